// ### nvp_pkg.sv
// package for the byte-wide nonvolatile data store controller
// assumes the cpu i/o port and the array sit on the same clock
`default_nettype none
package nvp_pkg;
    // i/o-space offsets of the controller registers
    localparam logic [5:0] NVP_OFS_GP0 = 6'h1e;
    localparam logic [5:0] NVP_OFS_CTRL = 6'h1f;
    localparam logic [5:0] NVP_OFS_DATA = 6'h20;
    localparam logic [5:0] NVP_OFS_ADDRL = 6'h21;
    localparam logic [5:0] NVP_OFS_ADDRH = 6'h22;
    localparam logic [5:0] NVP_OFS_STAT = 6'h23;
    localparam logic [5:0] NVP_OFS_GP1 = 6'h2a;
    localparam logic [5:0] NVP_OFS_GP2 = 6'h2b;
    // address windows
    localparam logic [5:0] NVP_BIT_LIMIT = 6'h1f;
    localparam logic [7:0] NVP_DSPACE_OFS = 8'h20;
    localparam logic [7:0] NVP_DSPACE_TOP = 8'h5f;
    // control register fields
    localparam int NVP_CR_RE = 0;
    localparam int NVP_CR_PE = 1;
    localparam int NVP_CR_MPE = 2;
    localparam int NVP_CR_RIE = 3;
    localparam int NVP_CR_PM_LO = 4;
    localparam int NVP_CR_PM_HI = 5;
    // status register fields
    localparam int NVP_ST_REFUSED = 0;
    // program modes
    localparam logic [1:0] NVP_PM_ATOMIC = 2'h0;
    localparam logic [1:0] NVP_PM_ERASE = 2'h1;
    localparam logic [1:0] NVP_PM_WRITE = 2'h2;
    localparam logic [1:0] NVP_PM_RSVD = 2'h3;
    // reset values
    localparam logic [7:0] NVP_RST_BYTE = 8'h00;
    localparam logic [8:0] NVP_RST_ADDR = 9'h000;
    // cycle counts on the cpu clock
    localparam logic [2:0] NVP_MPE_WINDOW = 3'h4;
    localparam logic [2:0] NVP_READ_HALT = 3'h4;
    localparam logic [2:0] NVP_PE_HALT = 3'h2;
    // program times in microseconds, counted in calibrated oscillator ticks
    localparam int NVP_ATOMIC_US = 3400;
    localparam int NVP_SPLIT_US = 1800;
    localparam int NVP_OSC_KHZ = 8000;
    localparam int NVP_ATOMIC_TICKS = NVP_ATOMIC_US * NVP_OSC_KHZ / 1000;
    localparam int NVP_SPLIT_TICKS = NVP_SPLIT_US * NVP_OSC_KHZ / 1000;

    typedef struct packed {
        logic wr;
        logic rd;
        logic bit_set;
        logic bit_clr;
        logic dspace;
        logic [2:0] bit_idx;
        logic [7:0] addr;
        logic [7:0] wdata;
    } nvp_io_req_t;

    typedef struct packed {
        logic erase;
        logic write;
        logic [8:0] addr;
        logic [7:0] data;
    } nvp_arr_cmd_t;

    typedef enum logic [1:0] {
        NVP_IDLE,
        NVP_ERASE,
        NVP_WRITE
    } nvp_state_t;

    typedef struct packed {
        nvp_state_t st;
        logic atomic;
        logic pe;
        logic [1:0] mode;
        logic rie;
        logic [2:0] mpe_cnt;
        logic [2:0] halt_cnt;
        logic refused;
        logic [8:0] addr;
        logic [7:0] data;
        logic [7:0] gp0;
        logic [7:0] gp1;
        logic [7:0] gp2;
        logic [7:0] rdata;
        nvp_arr_cmd_t arr;
    } nvp_regs_t;
endpackage
`default_nettype wire

// ### nvp_otimer.sv
// program-time counter stepped by the calibrated oscillator tick
// assumes i_tick is a one-cycle enable from the oscillator divider
`default_nettype none
module nvp_otimer import nvp_pkg::*; (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // oscillator enable
    input wire logic i_tick,
    // control
    input wire logic i_start,
    input wire logic [15:0] i_len,
    // status
    output logic o_busy,
    output logic o_done
);
    typedef struct packed {
        logic run;
        logic done;
        logic [15:0] cnt;
    } nvp_tmr_t;

    nvp_tmr_t r_ff;
    nvp_tmr_t nxt_r;

    always_comb begin
        nxt_r = r_ff;
        nxt_r.done = 1'b0;
        if (i_start) begin
            nxt_r.run = 1'b1;
            nxt_r.cnt = i_len;
        end else if (r_ff.run && i_tick) begin
            // cpu clock plays no part in the length, only oscillator ticks
            nxt_r.cnt = r_ff.cnt - 16'h0001;
            if (r_ff.cnt <= 16'h0001) begin
                nxt_r.run = 1'b0;
                nxt_r.done = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign o_busy = r_ff.run;
    assign o_done = r_ff.done;
endmodule
`default_nettype wire

// ### nvp_ctrl.sv
// cpu-side controller for byte erase, write and read of the data store
// assumes a single-cycle i/o port, a combinational array read and an
// oscillator tick enable; i_sys_rst is the system reset, i_nrst power-on
//
// Summary of operation
// - mode 00: enable pair starts atomic erase-write
// - program enable held through erase and write
// - busy refuses reads and further program requests
// - mode 01: enable pair starts erase only
// - erase-only keeps program enable until done
// - mode 10: enable pair starts write only
// - program time counted on calibrated oscillator
// - system reset lets running program finish
// - read enable loads addressed byte into data
// - writing one clears flag, zero keeps
// - bit set/clear touches only named bit
// - i/o address plus 0x20 in data space
// - nine-bit address, high register holds bit 8
// - three general-purpose bytes, only the low one bit-accessible
// - master enable self-clears after four cycles
// - mode locked while busy, reset to 00
// - atomic 3.4 ms, split 1.8 ms, 11 reserved
// - read halts cpu four, program two cycles
`default_nettype none
module nvp_ctrl import nvp_pkg::*; #(
    parameter logic [15:0] ATOMIC_TICKS = 16'(NVP_ATOMIC_TICKS),
    parameter logic [15:0] SPLIT_TICKS = 16'(NVP_SPLIT_TICKS)
) (
    // clock and resets
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_sys_rst,
    // calibrated oscillator enable
    input wire logic i_osc_tick,
    // cpu i/o port
    input wire nvp_io_req_t i_req,
    output logic [7:0] o_rdata,
    output logic o_cpu_halt,
    // array side
    output nvp_arr_cmd_t o_arr,
    input wire logic [7:0] i_arr_rdata,
    // status
    output logic o_nv_ready
);
    nvp_regs_t r_ff;
    nvp_regs_t nxt_r;
    logic tmr_start;
    logic [15:0] tmr_len;
    logic tmr_done;
    logic [7:0] io_addr;
    logic in_range;
    logic bit_op;
    logic [7:0] wm;
    logic [7:0] wv;
    logic pe_req;
    logic re_req;
    logic accept;

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] val,
                                         input logic [7:0] mask);
        merge = (old & ~mask) | (val & mask);
    endfunction

    function automatic logic hit(input logic [5:0] ofs, input logic [7:0] a,
                                 input logic ok, input logic [7:0] mask);
        hit = ok && (a[5:0] == ofs) && (mask != 8'h00);
    endfunction

    function automatic logic [7:0] ctrl_view(input nvp_regs_t s);
        ctrl_view = {2'b00, s.mode, s.rie, (s.mpe_cnt != 3'h0), s.pe, 1'b0};
    endfunction

    nvp_otimer u_tmr (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_tick(i_osc_tick),
        .i_start(tmr_start),
        .i_len(tmr_len),
        .o_busy(),
        .o_done(tmr_done)
    );

    always_comb begin
        nxt_r = r_ff;
        tmr_start = 1'b0;
        tmr_len = 16'h0000;
        nxt_r.arr.erase = 1'b0;
        nxt_r.arr.write = 1'b0;

        // data-space view sits 0x20 above the i/o view
        if (i_req.dspace) begin
            io_addr = i_req.addr - NVP_DSPACE_OFS;
            in_range = (i_req.addr >= NVP_DSPACE_OFS) && (i_req.addr <= NVP_DSPACE_TOP);
        end else begin
            io_addr = i_req.addr;
            in_range = (i_req.addr[7:6] == 2'b00);
        end
        bit_op = (i_req.bit_set || i_req.bit_clr) && in_range
                 && (io_addr[5:0] <= NVP_BIT_LIMIT);

        // single-bit ops carry a one-hot mask so neighbours stay untouched
        if (i_req.wr) begin
            wm = 8'hff;
            wv = i_req.wdata;
        end else if (bit_op) begin
            wm = 8'h01 << i_req.bit_idx;
            wv = i_req.bit_set ? 8'hff : 8'h00;
        end else begin
            wm = 8'h00;
            wv = 8'h00;
        end

        // master enable window
        if (r_ff.mpe_cnt != 3'h0) begin
            nxt_r.mpe_cnt = r_ff.mpe_cnt - 3'h1;
        end
        if (r_ff.halt_cnt != 3'h0) begin
            nxt_r.halt_cnt = r_ff.halt_cnt - 3'h1;
        end

        pe_req = hit(NVP_OFS_CTRL, io_addr, in_range, wm)
                 && wm[NVP_CR_PE] && wv[NVP_CR_PE];
        re_req = hit(NVP_OFS_CTRL, io_addr, in_range, wm)
                 && wm[NVP_CR_RE] && wv[NVP_CR_RE];
        accept = pe_req && (r_ff.mpe_cnt != 3'h0) && !r_ff.pe
                 && (r_ff.mode != NVP_PM_RSVD);

        if (hit(NVP_OFS_CTRL, io_addr, in_range, wm)) begin
            nxt_r.rie = merge({7'h00, r_ff.rie}, {7'h00, wv[NVP_CR_RIE]},
                              {7'h00, wm[NVP_CR_RIE]}) != 8'h00;
            if (!r_ff.pe) begin
                nxt_r.mode = merge({6'h00, r_ff.mode}, {6'h00, wv[NVP_CR_PM_HI:NVP_CR_PM_LO]},
                                   {6'h00, wm[NVP_CR_PM_HI:NVP_CR_PM_LO]}) != 8'h00
                             ? wv[NVP_CR_PM_HI:NVP_CR_PM_LO] & wm[NVP_CR_PM_HI:NVP_CR_PM_LO]
                               | r_ff.mode & ~wm[NVP_CR_PM_HI:NVP_CR_PM_LO]
                             : 2'b00;
            end
            if (wm[NVP_CR_MPE] && wv[NVP_CR_MPE]) begin
                nxt_r.mpe_cnt = NVP_MPE_WINDOW;
            end
        end

        // refused flag: write one clears; refusals further down still set it, so set wins
        if (hit(NVP_OFS_STAT, io_addr, in_range, wm) && wm[NVP_ST_REFUSED]
            && wv[NVP_ST_REFUSED]) begin
            nxt_r.refused = 1'b0;
        end

        // address and data are frozen while an operation runs
        if (hit(NVP_OFS_ADDRL, io_addr, in_range, wm) || hit(NVP_OFS_ADDRH, io_addr, in_range, wm)
            || hit(NVP_OFS_DATA, io_addr, in_range, wm)) begin
            if (r_ff.pe) begin
                nxt_r.refused = 1'b1;
            end else if (hit(NVP_OFS_ADDRL, io_addr, in_range, wm)) begin
                nxt_r.addr[7:0] = merge(r_ff.addr[7:0], wv, wm);
            end else if (hit(NVP_OFS_ADDRH, io_addr, in_range, wm)) begin
                nxt_r.addr[8] = (merge({7'h00, r_ff.addr[8]}, wv, wm) & 8'h01) != 8'h00;
            end else begin
                nxt_r.data = merge(r_ff.data, wv, wm);
            end
        end
        if (hit(NVP_OFS_GP0, io_addr, in_range, wm)) begin
            nxt_r.gp0 = merge(r_ff.gp0, wv, wm);
        end
        if (hit(NVP_OFS_GP1, io_addr, in_range, wm)) begin
            nxt_r.gp1 = merge(r_ff.gp1, wv, wm);
        end
        if (hit(NVP_OFS_GP2, io_addr, in_range, wm)) begin
            nxt_r.gp2 = merge(r_ff.gp2, wv, wm);
        end

        // read strobe: array answers in the same cycle
        if (re_req) begin
            if (r_ff.pe) begin
                nxt_r.refused = 1'b1;
            end else begin
                nxt_r.data = i_arr_rdata;
                nxt_r.halt_cnt = NVP_READ_HALT;
            end
        end
        if (pe_req && r_ff.pe) begin
            nxt_r.refused = 1'b1;
        end

        // program sequencer
        case (r_ff.st)
            NVP_IDLE: begin
                if (accept) begin
                    nxt_r.pe = 1'b1;
                    nxt_r.halt_cnt = NVP_PE_HALT;
                    nxt_r.arr.addr = r_ff.addr;
                    nxt_r.arr.data = r_ff.data;
                    tmr_start = 1'b1;
                    nxt_r.atomic = (r_ff.mode == NVP_PM_ATOMIC);
                    if (r_ff.mode == NVP_PM_WRITE) begin
                        nxt_r.arr.write = 1'b1;
                        tmr_len = SPLIT_TICKS;
                        nxt_r.st = NVP_WRITE;
                    end else begin
                        nxt_r.arr.erase = 1'b1;
                        // atomic total split evenly over erase and write
                        tmr_len = (r_ff.mode == NVP_PM_ATOMIC) ? (ATOMIC_TICKS >> 1)
                                                                 : SPLIT_TICKS;
                        nxt_r.st = NVP_ERASE;
                    end
                end
            end
            NVP_ERASE: begin
                if (tmr_done) begin
                    if (r_ff.atomic) begin
                        nxt_r.arr.write = 1'b1;
                        tmr_start = 1'b1;
                        tmr_len = ATOMIC_TICKS - (ATOMIC_TICKS >> 1);
                        nxt_r.st = NVP_WRITE;
                    end else begin
                        nxt_r.pe = 1'b0;
                        nxt_r.st = NVP_IDLE;
                    end
                end
            end
            NVP_WRITE: begin
                if (tmr_done) begin
                    nxt_r.pe = 1'b0;
                    nxt_r.atomic = 1'b0;
                    nxt_r.st = NVP_IDLE;
                end
            end
            default: begin
                nxt_r.st = NVP_IDLE;
                nxt_r.pe = 1'b0;
            end
        endcase

        // registered read data; reserved bits read zero
        if (i_req.rd && in_range) begin
            case (io_addr[5:0])
                NVP_OFS_CTRL: nxt_r.rdata = ctrl_view(r_ff);
                NVP_OFS_DATA: nxt_r.rdata = r_ff.data;
                NVP_OFS_ADDRL: nxt_r.rdata = r_ff.addr[7:0];
                NVP_OFS_ADDRH: nxt_r.rdata = {7'h00, r_ff.addr[8]};
                NVP_OFS_STAT: nxt_r.rdata = {7'h00, r_ff.refused};
                NVP_OFS_GP0: nxt_r.rdata = r_ff.gp0;
                NVP_OFS_GP1: nxt_r.rdata = r_ff.gp1;
                NVP_OFS_GP2: nxt_r.rdata = r_ff.gp2;
                default: nxt_r.rdata = NVP_RST_BYTE;
            endcase
        end else if (i_req.rd) begin
            nxt_r.rdata = NVP_RST_BYTE;
        end

        // system reset spares a running operation and its operands
        if (i_sys_rst) begin
            nxt_r.rie = 1'b0;
            nxt_r.mpe_cnt = 3'h0;
            nxt_r.halt_cnt = 3'h0;
            nxt_r.refused = 1'b0;
            nxt_r.gp0 = NVP_RST_BYTE;
            nxt_r.gp1 = NVP_RST_BYTE;
            nxt_r.gp2 = NVP_RST_BYTE;
            nxt_r.rdata = NVP_RST_BYTE;
            if (!r_ff.pe && !nxt_r.pe) begin
                nxt_r.mode = NVP_PM_ATOMIC;
                nxt_r.data = NVP_RST_BYTE;
                nxt_r.st = NVP_IDLE;
                nxt_r.arr.erase = 1'b0;
                nxt_r.arr.write = 1'b0;
                tmr_start = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            r_ff <= '0;
            r_ff.st <= NVP_IDLE;
            r_ff.addr <= NVP_RST_ADDR;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign o_rdata = r_ff.rdata;
    assign o_cpu_halt = (r_ff.halt_cnt != 3'h0);
    assign o_arr = r_ff.arr;
    assign o_nv_ready = r_ff.rie && !r_ff.pe;
endmodule
`default_nettype wire

// ### nvp_arr_model.sv
// behavioural byte array standing behind the controller
// assumes one-cycle erase and write pulses carrying address and data
`default_nettype none
module nvp_arr_model import nvp_pkg::*; (
    // clock
    input wire logic i_clk,
    // commands and read address
    input wire nvp_arr_cmd_t i_cmd,
    input wire logic [8:0] i_rd_addr,
    // read data
    output logic [7:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [512];
    initial for (int i = 0; i < 512; i++) mem[i] = 8'hff;
    always @(posedge i_clk) begin
        if (i_cmd.erase) mem[i_cmd.addr] <= 8'hff;
        // a write only clears bits, so an unerased cell comes out mangled
        if (i_cmd.write) mem[i_cmd.addr] <= mem[i_cmd.addr] & i_cmd.data;
    end
    assign o_rdata = mem[i_rd_addr];
endmodule
`default_nettype wire

// ### nvp_ctrl_checker.sv
// port assertions for the byte program controller
// assumes it is bound into nvp_ctrl and sees only its ports
`default_nettype none
module nvp_ctrl_checker import nvp_pkg::*; #(
    parameter logic [15:0] ATOMIC_TICKS = 16'(NVP_ATOMIC_TICKS),
    parameter logic [15:0] SPLIT_TICKS = 16'(NVP_SPLIT_TICKS)
) (
    // clock, resets and oscillator enable
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_sys_rst,
    input wire logic i_osc_tick,
    // cpu side
    input wire nvp_io_req_t i_req,
    input wire logic [7:0] o_rdata,
    input wire logic o_cpu_halt,
    // array side and ready status
    input wire nvp_arr_cmd_t o_arr,
    input wire logic [7:0] i_arr_rdata,
    input wire logic o_nv_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] HALF = ATOMIC_TICKS / 2;
    logic [15:0] tick_cnt_ff;
    // oscillator ticks since the last erase pulse
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) tick_cnt_ff <= '0;
        else if (o_arr.erase) tick_cnt_ff <= '0;
        else if (i_osc_tick) tick_cnt_ff <= tick_cnt_ff + 16'h1;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    a_cmd_exclusive: assert property (!(o_arr.erase && o_arr.write))
        else $error("erase and write pulses overlap");
    a_erase_pulse: assert property (o_arr.erase |=> !o_arr.erase)
        else $error("erase pulse longer than one cycle");
    a_write_pulse: assert property (o_arr.write |=> !o_arr.write)
        else $error("write pulse longer than one cycle");
    a_prog_halt: assert property (o_arr.erase |-> o_cpu_halt ##1 o_cpu_halt ##1 !o_cpu_halt)
        else $error("program start did not halt two cycles");
    a_busy_ready: assert property (o_arr.erase |=> !o_nv_ready [*3])
        else $error("ready shown while busy");
    a_addr_held: assert property (o_arr.erase |=> $stable(o_arr.addr) [*8])
        else $error("array address moved during operation");
    a_atomic_gap: assert property ((o_arr.write && !o_cpu_halt) |->
        (tick_cnt_ff >= HALF - 16'h1 && tick_cnt_ff <= HALF + 16'h1))
        else $error("atomic write phase not timed by oscillator");
    a_read_halt: assert property (($rose(o_cpu_halt) && !o_arr.erase && !o_arr.write) |->
        o_cpu_halt [*4] ##1 !o_cpu_halt)
        else $error("read halt not four cycles");
    a_rdata_hold: assert property ((!$past(i_req.rd) && !$past(i_sys_rst)) |->
        $stable(o_rdata))
        else $error("read data changed without a read");
endmodule
bind nvp_ctrl nvp_ctrl_checker #(.ATOMIC_TICKS(ATOMIC_TICKS), .SPLIT_TICKS(SPLIT_TICKS))
    u_nvp_ctrl_checker (.i_clk(i_clk), .i_nrst(i_nrst), .i_sys_rst(i_sys_rst),
    .i_osc_tick(i_osc_tick), .i_req(i_req), .o_rdata(o_rdata), .o_cpu_halt(o_cpu_halt),
    .o_arr(o_arr), .i_arr_rdata(i_arr_rdata), .o_nv_ready(o_nv_ready));
`default_nettype wire

// ### test_eeprom_byte_program_ctrl.sv
// self-checking bench for the byte program controller
// assumes nvp_arr_model as the array and the bound port checker
`default_nettype none
module test_eeprom_byte_program_ctrl import nvp_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    // short program times so the run stays brief
    localparam logic [15:0] AT = 16'h8;
    localparam logic [15:0] ST = 16'h4;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_sys_rst = 1'b0;
    logic i_osc_tick = 1'b0;
    logic tick_run = 1'b1;
    nvp_io_req_t i_req = '0;
    logic [7:0] o_rdata;
    logic [7:0] arr_rdata;
    logic o_cpu_halt;
    logic o_nv_ready;
    nvp_arr_cmd_t o_arr;
    logic [8:0] rd_addr = 9'h000;
    logic [31:0] lfsr = 32'hd678;
    logic [7:0] shadow [512];
    logic [15:0] exp_q [$];
    logic [5:0] gp [3] = '{NVP_OFS_GP0, NVP_OFS_GP1, NVP_OFS_GP2};
    logic [5:0] offs [9] = '{NVP_OFS_GP0, NVP_OFS_CTRL, NVP_OFS_DATA, NVP_OFS_ADDRL,
        NVP_OFS_ADDRH, NVP_OFS_STAT, NVP_OFS_GP1, NVP_OFS_GP2, 6'h3f};
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;
    int tick_div = 0;

    nvp_ctrl #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(ST)) u_nvp_ctrl (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_sys_rst(i_sys_rst), .i_osc_tick(i_osc_tick), .i_req(i_req), .o_rdata(o_rdata),
        .o_cpu_halt(o_cpu_halt), .o_arr(o_arr), .i_arr_rdata(arr_rdata),
        .o_nv_ready(o_nv_ready));
    nvp_arr_model u_nvp_arr_model (.i_clk(i_clk), .i_cmd(o_arr), .i_rd_addr(rd_addr),
        .o_rdata(arr_rdata));

    always #4 i_clk = ~i_clk;
    // oscillator tick every third cycle, can be paused
    always @(negedge i_clk) begin
        tick_div <= (tick_div == 2) ? 0 : tick_div + 1;
        i_osc_tick <= tick_run && (tick_div == 2);
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic report_and_stop();
        $display("counts: %0d checks, %0d mismatches", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [15:0] e);
        if (e[15:8] === 8'h00) return;
        checks_done++;
        if ((got & e[15:8]) !== e[7:0]) begin
            err_total++;
            $display("FAIL %0t: read %h expected %h", $time, got, e[7:0]);
        end
    endtask

    task automatic check1(input logic got, input logic e);
        checks_done++;
        if (got !== e) begin
            err_total++;
            $display("FAIL %0t: ready level %b expected %b", $time, got, e);
        end
    endtask

    task automatic op(input int k, input logic [5:0] a, input logic [7:0] d,
                      input logic ds = 1'b0);
        @(negedge i_clk);
        i_req <= '{wr: k == 0, rd: k == 1, bit_set: k == 2, bit_clr: k == 3, dspace: ds,
                   bit_idx: d[2:0], addr: ds ? 8'(a) + NVP_DSPACE_OFS : 8'(a), wdata: d};
    endtask

    task automatic idle(input int n);
        repeat (n) begin
            @(negedge i_clk);
            i_req <= '0;
        end
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
        exp_q.push_back({m, e & m});
        op(1, a, 8'h00);
    endtask

    task automatic set_addr(input logic [8:0] a);
        op(0, NVP_OFS_ADDRH, {7'h00, a[8]});
        op(0, NVP_OFS_ADDRL, a[7:0]);
        rd_addr = a;
    endtask

    task automatic prog(input logic [1:0] m, input logic [8:0] a, input logic [7:0] d,
                        input int gap);
        op(0, NVP_OFS_CTRL, {2'b00, m, 4'h8});
        set_addr(a);
        op(0, NVP_OFS_DATA, d);
        op(2, NVP_OFS_CTRL, 8'(NVP_CR_MPE));
        idle(gap);
        op(2, NVP_OFS_CTRL, 8'(NVP_CR_PE));
        idle(1);
    endtask

    task automatic expect_byte(input logic [8:0] a, input logic [7:0] e);
        set_addr(a);
        op(2, NVP_OFS_CTRL, 8'(NVP_CR_RE));
        rd(NVP_OFS_DATA, e);
        idle(4);
    endtask

    // poll the busy bit as software would, bounded
    task automatic wait_idle();
        for (int i = 0; i < 200; i++) begin
            rd(NVP_OFS_CTRL, 8'h00, 8'h00);
            @(posedge i_clk);
            #1;
            if (o_rdata[NVP_CR_PE] === 1'b0) return;
        end
        err_total++;
        $display("FAIL %0t: program never finished", $time);
    endtask

    always @(posedge i_clk) begin
        if (i_nrst && i_req.rd) begin
            #1;
            check8(o_rdata, exp_q.pop_front());
        end
    end

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_total++;
            $display("FAIL %0t: run did not finish", $time);
            report_and_stop();
        end
    end

    initial begin
        logic [7:0] v;
        logic [8:0] a9;
        for (int i = 0; i < 512; i++) shadow[i] = 8'hff;
        repeat (6) @(posedge i_clk);
        @(negedge i_clk);
        i_nrst <= 1'b1;
        foreach (offs[i]) rd(offs[i], 8'h00);
        $display("reset values done");
        for (int i = 0; i < 3; i++) begin
            lfsr = lfsr_next(lfsr);
            v = lfsr[7:0];
            op(0, gp[i], v, 1'b1);
            rd(gp[i], v);
            op(2, gp[i], {5'h00, lfsr[10:8]});
            op(3, gp[i], {5'h00, lfsr[13:11]});
            if (i == 0) v = (v | (8'h01 << lfsr[10:8])) & ~(8'h01 << lfsr[13:11]);
            rd(gp[i], v);
        end
        $display("register access done");
        a9 = {1'b1, lfsr[23:16]};
        for (int m = 0; m < 4; m++) begin
            lfsr = lfsr_next(lfsr);
            prog(2'(m), a9, lfsr[7:0], m % 3);
            wait_idle();
            check1(o_nv_ready, 1'b1);
            if (m == 0) shadow[a9] = lfsr[7:0];
            if (m == 1) shadow[a9] = 8'hff;
            if (m == 2) shadow[a9] = shadow[a9] & lfsr[7:0];
            expect_byte(a9, shadow[a9]);
        end
        rd(NVP_OFS_ADDRH, 8'h01);
        prog(NVP_PM_ERASE, a9, 8'h00, 4);
        wait_idle();
        expect_byte(a9, shadow[a9]);
        $display("program modes done");
        v = lfsr[15:8];
        a9 = {1'b0, lfsr[7:0]};
        prog(NVP_PM_ATOMIC, a9, v, 0);
        tick_run <= 1'b0;
        op(0, NVP_OFS_CTRL, 8'h30);
        op(0, NVP_OFS_ADDRL, ~a9[7:0]);
        op(2, NVP_OFS_CTRL, 8'(NVP_CR_RE));
        idle(30);
        rd(NVP_OFS_CTRL, 8'h02, 8'h32);
        rd(NVP_OFS_STAT, 8'h01);
        rd(NVP_OFS_ADDRL, a9[7:0]);
        rd(NVP_OFS_DATA, v);
        op(0, NVP_OFS_STAT, 8'h00);
        rd(NVP_OFS_STAT, 8'h01);
        op(0, NVP_OFS_STAT, 8'h01);
        rd(NVP_OFS_STAT, 8'h00);
        idle(1);
        i_sys_rst <= 1'b1;
        idle(1);
        i_sys_rst <= 1'b0;
        tick_run <= 1'b1;
        wait_idle();
        check1(o_nv_ready, 1'b0);
        expect_byte(a9, v);
        idle(3);
        $display("busy refusal and reset survival done");
        report_and_stop();
    end
endmodule
`default_nettype wire
